// File: inc/tss_consts.svh
// register map, field positions and reset values of the timer signal selection block
// assumes inclusion by bare name from design files that need the constants
`ifndef TSS_CONSTS_SVH
`define TSS_CONSTS_SVH

// byte addresses on the apb bus
`define TSS_SEL_ADDR 16'h8000
`define TSS_STAT_ADDR 16'h8004

// selection register fields
`define TSS_WDOG_DIR_BIT 5
`define TSS_TMR1_DIR_BIT 4
`define TSS_TMR0_DIR_BIT 3
`define TSS_ROUTE_HI 2
`define TSS_ROUTE_LO 1
`define TSS_DUAL_BIT 0
`define TSS_SEL_RESET 16'h0001
`define TSS_SEL_WMASK 16'h003f

// status register fields
`define TSS_ST_PINS_HI 2
`define TSS_ST_PINS_LO 0
`define TSS_ST_NMI_BIT 3
`define TSS_ST_RST_BIT 4
`define TSS_ST_EXT_IRQ_THREE_BIT 5

// pin indices inside the pin group
`define TSS_PIN_TMR0 0
`define TSS_PIN_TMR1 1
`define TSS_PIN_WDOG 2

`endif

// File: inc/tss_pkg.sv
// types shared by the timer signal selection design files
// assumes nothing beyond a systemverilog compiler
package tss_pkg;

    // where the watchdog interrupt is steered
    typedef enum logic [1:0] {
        ROUTE_NONE  = 2'b00,
        ROUTE_RESET = 2'b01,
        ROUTE_NMI   = 2'b10,
        ROUTE_EXT_IRQ_THREE  = 2'b11
    } wdog_route_t;

    typedef logic [15:0] sel_word_t;

endpackage

// File: core/sync_bits.sv
// two-flop synchroniser, one stage pair per bit
// assumes asynchronous inputs and one destination clock
`timescale 1ns/1ps
module sync_bits #(
    parameter int WIDTH = 3
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic arst_n_i,
    // bits
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    generate
        if (WIDTH < 1) begin : g_bad
            $error("sync_bits needs at least one bit");
        end
    endgenerate

    genvar b;
    generate
        for (b = 0; b < WIDTH; b++) begin : g_bit
            logic meta_r;
            logic hold_r;
            always_ff @(posedge mclk_i or negedge arst_n_i) begin
                if (!arst_n_i) begin
                    meta_r <= 1'b0;
                    hold_r <= 1'b0;
                end else begin
                    meta_r <= async_i[b];
                    hold_r <= meta_r;
                end
            end
            assign sync_o[b] = hold_r;
        end
    endgenerate
endmodule

// File: core/timer_pin_mux.sv
// one timer pin: steers the pin to the timer input or drives it from the timer output
// assumes the pin level is already synchronised and the controls are on mclk_i
`timescale 1ns/1ps
module timer_pin_mux (
    // clock and reset
    input wire logic mclk_i,
    input wire logic arst_n_i,
    // control
    input wire logic owned_i,
    input wire logic dir_out_i,
    // timer side
    input wire logic timer_output_i,
    output logic timer_input_o,
    // pin side
    input wire logic pin_sync_i,
    output logic pin_o,
    output logic pin_oe_o
);
    wire drive_w = owned_i & dir_out_i;
    wire sense_w = owned_i & ~dir_out_i;

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pin_o <= 1'b0;
            pin_oe_o <= 1'b0;
            timer_input_o <= 1'b0;
        end else begin
            pin_o <= drive_w & timer_output_i;
            pin_oe_o <= drive_w;
            timer_input_o <= sense_w & pin_sync_i;
        end
    end
endmodule

// File: core/timer_signal_selection.sv
// timer signal selection: apb register, timer pin steering, watchdog interrupt routing
// assumes an apb master on mclk_i, timers and interrupt logic on the same clock
`timescale 1ns/1ps
`include "tss_consts.svh"
module timer_signal_selection #(
    parameter int ADDR_W = 16
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic arst_n_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // timer 0 pin and timer
    input wire logic timer0_pin_i,
    output logic timer0_pin_o,
    output logic timer0_pin_oe_o,
    input wire logic timer0_output_i,
    output logic timer0_input_o,
    // timer 1 pin and timer
    input wire logic timer1_pin_i,
    output logic timer1_pin_o,
    output logic timer1_pin_oe_o,
    input wire logic timer1_output_i,
    output logic timer1_input_o,
    // shared watchdog / nmi pin (nmi function is active low)
    input wire logic wdog_pin_i,
    output logic wdog_pin_o,
    output logic wdog_pin_oe_o,
    input wire logic wdog_output_i,
    output logic wdog_input_o,
    // watchdog interrupt and its destinations
    input wire logic wdog_timer_irq_i,
    input wire logic ext_irq_three_en_i,
    output logic wdog_reset_req_o,
    output logic nmi_req_o,
    output logic ext_irq_three_o
);
    import tss_pkg::*;

    localparam int NPINS = 3;

    generate
        if (ADDR_W < 16 || ADDR_W > 32) begin : g_bad_addr
            $error("timer_signal_selection needs ADDR_W between 16 and 32");
        end
    endgenerate

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    sel_word_t sel_r;
    sel_word_t sel_nxt;
    logic pready_r;
    logic pslverr_r;
    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;
    logic nmi_req_r;
    logic rst_req_r;
    logic ext_irq_three_r;

    // ------------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------------
    // one wait state so every bus answer comes from a flop
    wire access_w = psel_i & penable_i & ~pready_r;
    wire done_w = psel_i & penable_i & pready_r;
    wire [15:0] addr_lo_w = paddr_i[15:0];
    // a reversed part-select on a 16-bit bus would not elaborate, so split by generate
    logic hi_zero_w;
    generate
        if (ADDR_W == 16) begin : g_addr16
            assign hi_zero_w = 1'b1;
        end else begin : g_addr_wide
            assign hi_zero_w = (paddr_i[ADDR_W-1:16] == '0);
        end
    endgenerate
    wire hit_sel_w = hi_zero_w & (addr_lo_w == `TSS_SEL_ADDR);
    wire hit_stat_w = hi_zero_w & (addr_lo_w == `TSS_STAT_ADDR);
    wire hit_w = hit_sel_w | hit_stat_w;
    // status register is read only; a write to it is refused
    wire bad_w = ~hit_w | (pwrite_i & hit_stat_w);
    // only lane 0 holds writable bits, lane 1 is all reserved
    wire wr_sel_w = done_w & pwrite_i & hit_sel_w & pstrb_i[0];

    assign sel_nxt = wr_sel_w
        ? ((sel_r & ~`TSS_SEL_WMASK) | (pwdata_i[15:0] & `TSS_SEL_WMASK))
        : sel_r;

    // ------------------------------------------------------------------
    // field views
    // ------------------------------------------------------------------
    wire dual_nmi_w = sel_r[`TSS_DUAL_BIT];
    wire [1:0] route_bits_w = sel_r[`TSS_ROUTE_HI:`TSS_ROUTE_LO];
    wdog_route_t route_w;
    assign route_w = wdog_route_t'(route_bits_w);

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    logic [NPINS-1:0] pin_async_w;
    logic [NPINS-1:0] pin_sync_w;
    assign pin_async_w[`TSS_PIN_TMR0] = timer0_pin_i;
    assign pin_async_w[`TSS_PIN_TMR1] = timer1_pin_i;
    assign pin_async_w[`TSS_PIN_WDOG] = wdog_pin_i;

    sync_bits #(
        .WIDTH(NPINS)
    ) u_pin_sync (
        .mclk_i(mclk_i),
        .arst_n_i(arst_n_i),
        .async_i(pin_async_w),
        .sync_o(pin_sync_w)
    );

    // ------------------------------------------------------------------
    // timer pin steering
    // ------------------------------------------------------------------
    logic [NPINS-1:0] dir_out_w;
    logic [NPINS-1:0] owned_w;
    logic [NPINS-1:0] tmr_out_w;
    logic [NPINS-1:0] tmr_in_w;
    logic [NPINS-1:0] pin_out_w;
    logic [NPINS-1:0] pin_oe_w;

    assign dir_out_w[`TSS_PIN_TMR0] = sel_r[`TSS_TMR0_DIR_BIT];
    assign dir_out_w[`TSS_PIN_TMR1] = sel_r[`TSS_TMR1_DIR_BIT];
    assign dir_out_w[`TSS_PIN_WDOG] = sel_r[`TSS_WDOG_DIR_BIT];

    // the shared pin belongs to the watchdog only outside nmi mode
    assign owned_w[`TSS_PIN_TMR0] = 1'b1;
    assign owned_w[`TSS_PIN_TMR1] = 1'b1;
    assign owned_w[`TSS_PIN_WDOG] = ~dual_nmi_w;

    assign tmr_out_w[`TSS_PIN_TMR0] = timer0_output_i;
    assign tmr_out_w[`TSS_PIN_TMR1] = timer1_output_i;
    assign tmr_out_w[`TSS_PIN_WDOG] = wdog_output_i;

    genvar p;
    generate
        for (p = 0; p < NPINS; p++) begin : g_pin
            timer_pin_mux u_mux (
                .mclk_i(mclk_i),
                .arst_n_i(arst_n_i),
                .owned_i(owned_w[p]),
                .dir_out_i(dir_out_w[p]),
                .timer_output_i(tmr_out_w[p]),
                .timer_input_o(tmr_in_w[p]),
                .pin_sync_i(pin_sync_w[p]),
                .pin_o(pin_out_w[p]),
                .pin_oe_o(pin_oe_w[p])
            );
        end
    endgenerate

    assign timer0_pin_o = pin_out_w[`TSS_PIN_TMR0];
    assign timer0_pin_oe_o = pin_oe_w[`TSS_PIN_TMR0];
    assign timer0_input_o = tmr_in_w[`TSS_PIN_TMR0];
    assign timer1_pin_o = pin_out_w[`TSS_PIN_TMR1];
    assign timer1_pin_oe_o = pin_oe_w[`TSS_PIN_TMR1];
    assign timer1_input_o = tmr_in_w[`TSS_PIN_TMR1];
    assign wdog_pin_o = pin_out_w[`TSS_PIN_WDOG];
    assign wdog_pin_oe_o = pin_oe_w[`TSS_PIN_WDOG];
    assign wdog_input_o = tmr_in_w[`TSS_PIN_WDOG];

    // ------------------------------------------------------------------
    // watchdog interrupt routing
    // ------------------------------------------------------------------
    wire to_reset_w = (route_w == ROUTE_RESET);
    wire to_nmi_w = (route_w == ROUTE_NMI);
    wire to_ext_irq_three_w = (route_w == ROUTE_EXT_IRQ_THREE);
    // route none keeps the watchdog interrupt from every destination; the pin nmi still acts
    wire routed_w = (route_w != ROUTE_NONE);

    // nmi pin is active low; pin is masked out when the watchdog owns nmi
    wire pin_nmi_w = dual_nmi_w & ~to_nmi_w & ~pin_sync_w[`TSS_PIN_WDOG];
    wire wdog_nmi_w = routed_w & to_nmi_w & wdog_timer_irq_i;
    wire nmi_nxt = pin_nmi_w | wdog_nmi_w;

    wire rst_nxt = routed_w & to_reset_w & wdog_timer_irq_i;
    // interrupt three is masked by the cpu's own enable bit
    wire ext_irq_three_nxt = routed_w & to_ext_irq_three_w & wdog_timer_irq_i & ext_irq_three_en_i;

    // ------------------------------------------------------------------
    // read data
    // ------------------------------------------------------------------
    logic [31:0] stat_w;
    always_comb begin
        stat_w = 32'h0000_0000;
        stat_w[`TSS_ST_PINS_HI:`TSS_ST_PINS_LO] = pin_sync_w;
        stat_w[`TSS_ST_NMI_BIT] = nmi_req_r;
        stat_w[`TSS_ST_RST_BIT] = rst_req_r;
        stat_w[`TSS_ST_EXT_IRQ_THREE_BIT] = ext_irq_three_r;
    end

    // reserved bits 15:6 and the upper half read as zero
    assign prdata_nxt = (access_w & ~pwrite_i & hit_sel_w) ? {16'h0000, sel_r}
                      : (access_w & ~pwrite_i & hit_stat_w) ? stat_w
                      : 32'h0000_0000;

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sel_r <= `TSS_SEL_RESET;
        end else begin
            sel_r <= sel_nxt;
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end else begin
            pready_r <= access_w;
            pslverr_r <= access_w & bad_w;
            prdata_r <= prdata_nxt;
        end
    end

    // routed events are registered, so a new setting acts one cycle after the write
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            nmi_req_r <= 1'b0;
            rst_req_r <= 1'b0;
            ext_irq_three_r <= 1'b0;
        end else begin
            nmi_req_r <= nmi_nxt;
            rst_req_r <= rst_nxt;
            ext_irq_three_r <= ext_irq_three_nxt;
        end
    end

    assign prdata_o = prdata_r;
    assign pready_o = pready_r;
    assign pslverr_o = pslverr_r;
    assign nmi_req_o = nmi_req_r;
    assign wdog_reset_req_o = rst_req_r;
    assign ext_irq_three_o = ext_irq_three_r;
endmodule

// File: verif/tss_chk_sva.sv
// assertion checker for the timer signal selection block
// assumes it is bound into the top module and sees its ports only
`timescale 1ns/1ps
`include "tss_consts.svh"
module tss_chk
    import tss_pkg::*;
#(
    parameter int ADDR_W = 16
) (
    input wire logic mclk_i, arst_n_i, psel_i, penable_i, pwrite_i, pready_o,
    input wire logic [ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    input wire logic timer0_output_i, timer0_pin_o, timer0_pin_oe_o, timer1_pin_i, timer1_input_o,
    input wire logic wdog_pin_i, wdog_pin_oe_o, wdog_timer_irq_i, ext_irq_three_en_i,
    input wire logic wdog_reset_req_o, nmi_req_o, ext_irq_three_o,
    input wire logic timer1_output_i, timer1_pin_o, wdog_output_i, wdog_pin_o
);
    // shadow of the selection register, updated at the completing edge
    logic [5:0] sel_r;
    logic [1:0] up_r;
    wire sel_wr = psel_i && penable_i && pready_o && pwrite_i && pstrb_i[0] && paddr_i == ADDR_W'(`TSS_SEL_ADDR);
    wire [1:0] route = sel_r[2:1];
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sel_r <= 6'h01;
            up_r <= 2'h0;
        end else begin
            if (sel_wr) sel_r <= pwdata_i[5:0];
            // pin paths need three edges of history after reset
            if (up_r != 2'h3) up_r <= up_r + 2'h1;
        end
    end
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!arst_n_i);
    property p_rst; 1 |=> wdog_reset_req_o == $past(route == ROUTE_RESET && wdog_timer_irq_i); endproperty
    a_rst: assert property (p_rst) else $error("reset request wrong");
    property p_ext_irq_three;
        1 |=> ext_irq_three_o == $past(route == ROUTE_EXT_IRQ_THREE && wdog_timer_irq_i && ext_irq_three_en_i);
    endproperty
    a_ext_irq_three: assert property (p_ext_irq_three) else $error("interrupt three wrong");
    property p_none; route == ROUTE_NONE |=> !wdog_reset_req_o && !ext_irq_three_o; endproperty
    a_none: assert property (p_none) else $error("unrouted watchdog reached a target");
    property p_nmi;
        up_r == 2'h3 |=> nmi_req_o == (($past(sel_r[0]) && $past(route) != ROUTE_NMI && !$past(wdog_pin_i, 3))
            || ($past(route) == ROUTE_NMI && $past(wdog_timer_irq_i)));
    endproperty
    a_nmi: assert property (p_nmi) else $error("nmi request wrong");
    property p_t0oe; 1 |=> timer0_pin_oe_o == $past(sel_r[3]); endproperty
    a_t0oe: assert property (p_t0oe) else $error("timer 0 pin enable wrong");
    property p_t0drv; sel_r[3] |=> timer0_pin_o == $past(timer0_output_i); endproperty
    a_t0drv: assert property (p_t0drv) else $error("timer 0 pin drive wrong");
    property p_wdoe; 1 |=> wdog_pin_oe_o == $past(sel_r[5] && !sel_r[0]); endproperty
    a_wdoe: assert property (p_wdoe) else $error("watchdog pin enable wrong");
    property p_t1in; up_r == 2'h3 |=> timer1_input_o == ($past(!sel_r[4]) && $past(timer1_pin_i, 3)); endproperty
    a_t1in: assert property (p_t1in) else $error("timer 1 input wrong");
    property p_t1drv; sel_r[4] |=> timer1_pin_o == $past(timer1_output_i); endproperty
    a_t1drv: assert property (p_t1drv) else $error("timer 1 pin drive wrong");
    property p_wddrv; sel_r[5] && !sel_r[0] |=> wdog_pin_o == $past(wdog_output_i); endproperty
    a_wddrv: assert property (p_wddrv) else $error("watchdog pin drive wrong");
endmodule
bind timer_signal_selection tss_chk #(.ADDR_W(ADDR_W)) u_chk (.*);

// File: verif/tss_timers_model.sv
// timers and cpu interrupt side facing the selection block
// assumes the bench commands the watchdog interrupt and the ext_irq_three enable
`timescale 1ns/1ps
module tss_timers_model (
    input wire logic mclk_i,
    input wire logic arst_n_i,
    input wire logic irq_cmd_i,
    input wire logic en_cmd_i,
    output logic timer0_output_o,
    output logic timer1_output_o,
    output logic wdog_output_o,
    output logic wdog_timer_irq_o,
    output logic ext_irq_three_en_o
);
    logic [2:0] cnt_r;
    // different rates so a swapped pin route shows up
    assign timer0_output_o = cnt_r[0];
    assign timer1_output_o = cnt_r[1];
    assign wdog_output_o = ~cnt_r[2];
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt_r <= 3'h0;
            wdog_timer_irq_o <= 1'b0;
            ext_irq_three_en_o <= 1'b0;
        end else begin
            cnt_r <= cnt_r + 3'h1;
            wdog_timer_irq_o <= irq_cmd_i;
            ext_irq_three_en_o <= en_cmd_i;
        end
    end
endmodule

// File: verif/timer_signal_selection_tb.sv
// bench for the timer signal selection block over apb
// assumes the checker is bound and the timers model sits on the far side
`timescale 1ns/1ps
module timer_signal_selection_tb;
    logic mclk_i, arst_n_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
    logic [15:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o;
    logic [3:0] pstrb_i;
    logic timer0_pin_o, timer0_pin_oe_o, timer0_output_i, timer0_input_o;
    logic timer1_pin_o, timer1_pin_oe_o, timer1_output_i, timer1_input_o;
    logic wdog_pin_o, wdog_pin_oe_o, wdog_output_i, wdog_input_o;
    logic wdog_timer_irq_i, ext_irq_three_en_i, wdog_reset_req_o, nmi_req_o, ext_irq_three_o;
    logic irq_cmd, en_cmd;
    logic [2:0] lvl;
    int errors, n_compared, cycles;
    // a driven pin reads back its own drive
    wire timer0_pin_i = timer0_pin_oe_o ? timer0_pin_o : lvl[0];
    wire timer1_pin_i = timer1_pin_oe_o ? timer1_pin_o : lvl[1];
    wire wdog_pin_i = wdog_pin_oe_o ? wdog_pin_o : lvl[2];
    timer_signal_selection #(.ADDR_W(16)) dut (.*);
    tss_timers_model far (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .irq_cmd_i(irq_cmd), .en_cmd_i(en_cmd),
        .timer0_output_o(timer0_output_i), .timer1_output_o(timer1_output_i), .wdog_output_o(wdog_output_i),
        .wdog_timer_irq_o(wdog_timer_irq_i), .ext_irq_three_en_o(ext_irq_three_en_i));
    task automatic close_out();
        $display("compared %0d, errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // entered just after an edge; leaves one idle cycle behind
    task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d, input logic [31:0] exp,
        input logic e);
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge mclk_i);
        penable_i <= 1'b1;
        do @(posedge mclk_i); while (pready_o !== 1'b1);
        if (!wr) chk(prdata_o, exp, "read data");
        chk(32'(pslverr_o), 32'(e), "response");
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge mclk_i);
    endtask
    task automatic routes(input logic [2:0] exp, input string what);
        chk(32'({wdog_reset_req_o, nmi_req_o, ext_irq_three_o}), 32'(exp), what);
    endtask
    initial begin
        mclk_i = 1'b0;
        forever #20 mclk_i = ~mclk_i;
    end
    always @(posedge mclk_i) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            errors++;
            $display("MISMATCH at %0t: run too long", $time);
            close_out();
        end
    end
    initial begin
        {arst_n_i, psel_i, penable_i, pwrite_i, irq_cmd, en_cmd} = 6'h00;
        paddr_i = 16'h0000;
        pwdata_i = 32'h0000_0000;
        pstrb_i = 4'hf;
        lvl = 3'h7;
        repeat (5) @(posedge mclk_i);
        arst_n_i <= 1'b1;
        repeat (4) @(posedge mclk_i);
        chk(32'({wdog_pin_oe_o, timer1_pin_oe_o, timer0_pin_oe_o}), 32'h0000_0000, "pins after reset");
        apb(1'b0, 16'h8000, 32'h0000_0000, 32'h0000_0001, 1'b0);
        lvl[2] <= 1'b0;
        repeat (5) @(posedge mclk_i);
        routes(3'h2, "pin nmi");
        lvl[2] <= 1'b1;
        for (int r = 0; r < 4; r++) begin
            apb(1'b1, 16'h8000, 32'(2 * r), 32'h0000_0000, 1'b0);
            for (int e = 0; e < 2; e++) begin
                en_cmd <= e[0];
                irq_cmd <= 1'b1;
                repeat (3) @(posedge mclk_i);
                routes({r == 1, r == 2, r == 3 && e == 1}, "watchdog route");
                irq_cmd <= 1'b0;
                repeat (3) @(posedge mclk_i);
                routes(3'h0, "route idle");
            end
        end
        apb(1'b1, 16'h8000, 32'h0000_0005, 32'h0000_0000, 1'b0);
        lvl[2] <= 1'b0;
        repeat (5) @(posedge mclk_i);
        routes(3'h0, "pin ignored");
        irq_cmd <= 1'b1;
        repeat (3) @(posedge mclk_i);
        routes(3'h2, "watchdog owns nmi");
        irq_cmd <= 1'b0;
        lvl[2] <= 1'b1;
        apb(1'b1, 16'h8000, 32'h0000_ffff, 32'h0000_0000, 1'b0);
        apb(1'b0, 16'h8000, 32'h0000_0000, 32'h0000_003f, 1'b0);
        chk(32'({wdog_pin_oe_o, timer1_pin_oe_o, timer0_pin_oe_o}), 32'h0000_0003, "nmi pin kept");
        apb(1'b1, 16'h8000, 32'h0000_003e, 32'h0000_0000, 1'b0);
        @(posedge mclk_i);
        chk(32'({wdog_pin_oe_o, timer1_pin_oe_o, timer0_pin_oe_o}), 32'h0000_0007, "pins out");
        apb(1'b1, 16'h8000, 32'h0000_0001, 32'h0000_0000, 1'b0);
        lvl <= 3'h5;
        repeat (5) @(posedge mclk_i);
        chk(32'({wdog_input_o, timer1_input_o, timer0_input_o}), 32'h0000_0001, "timer inputs");
        apb(1'b0, 16'h8004, 32'h0000_0000, 32'h0000_0005, 1'b0);
        apb(1'b1, 16'h8004, 32'h0000_003e, 32'h0000_0000, 1'b1);
        pstrb_i <= 4'he;
        apb(1'b1, 16'h8000, 32'h0000_003e, 32'h0000_0000, 1'b0);
        pstrb_i <= 4'hf;
        apb(1'b0, 16'h8000, 32'h0000_0000, 32'h0000_0001, 1'b0);
        apb(1'b0, 16'h8010, 32'h0000_0000, 32'h0000_0000, 1'b1);
        close_out();
    end
endmodule
